// ### inc/pmi_pkg.sv
package pmi_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_RESET_MASK_S = 8'h00;
    localparam logic [7:0] OFS_ISO_STATUS_S = 8'h04;
    localparam logic [7:0] OFS_ISO_MASK_S = 8'h08;
    localparam logic [7:0] OFS_EP_STATUS_NS = 8'h0C;
    localparam logic [7:0] OFS_EP_MASK_NS = 8'h10;
    localparam logic [7:0] OFS_FAULT_STATUS_NS = 8'h14;
    localparam logic [7:0] OFS_FAULT_MASK_NS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
    // Status and control field layout
    localparam int COUNT_LSB = 16;
    localparam int COUNT_W = 9;
    localparam int ROLE_BIT = 8;
    localparam int TAG_LSB = 0;
    localparam int TAG_W = 8;
    localparam int MASK_BIT = 0;
    // Reset values
    localparam logic MASK_RST = 1'b0;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
    // Category index
    localparam int CAT_RESET = 0;
    localparam int CAT_ISO = 1;
    localparam int CAT_EP = 2;
    localparam int CAT_FAULT = 3;
    localparam int NCAT = 4;
endpackage

// ### rtl/pmi_category.sv
`timescale 1ns/1ps
// One interrupt category: count of asserting interfaces and first raiser capture
module pmi_category #(
    parameter int NPORT = 8
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [NPORT-1:0] req_i,
    input wire logic [NPORT-1:0] role_i,
    input wire logic [NPORT*pmi_pkg::TAG_W-1:0] tag_i,
    output logic [pmi_pkg::COUNT_W-1:0] count_o,
    output logic role_o,
    output logic [pmi_pkg::TAG_W-1:0] tag_o,
    output logic rise_o
);
    // The count field is nine bits wide, so more interfaces cannot be reported
    if (NPORT < 1 || NPORT > 511) begin : g_bad_nport
        $error("pmi_category: NPORT out of range");
    end

    typedef struct packed {
        logic [pmi_pkg::COUNT_W-1:0] count;
        logic role;
        logic [pmi_pkg::TAG_W-1:0] tag;
        logic rise;
    } pmi_cat_state_t;

    pmi_cat_state_t st, next_st;

    always_comb begin
        logic [pmi_pkg::COUNT_W-1:0] cnt;
        logic found;
        cnt = '0;
        found = 1'b0;
        next_st = st;
        for (int i = 0; i < NPORT; i++) begin
            cnt = cnt + pmi_pkg::COUNT_W'(req_i[i]);
        end
        next_st.count = cnt;
        next_st.rise = 1'b0;
        if (st.count == '0) begin
            // Lowest numbered asserting port wins when several rise together
            for (int i = NPORT - 1; i >= 0; i--) begin
                if (req_i[i]) begin
                    found = 1'b1;
                    next_st.tag = tag_i[i*pmi_pkg::TAG_W +: pmi_pkg::TAG_W];
                    next_st.role = role_i[i];
                end
            end
            next_st.rise = found;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count_o = st.count;
    assign role_o = st.role;
    assign tag_o = st.tag;
    assign rise_o = st.rise;
endmodule // pmi_category

// ### rtl/pmi_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - Writing 1 to bit 0 of a control register masks that category's interrupts.
// - Status count field gives interfaces currently asserting the category.
// - Role bit reads 0 for slave, 1 for master interface.
// - Fault status holds first-raiser identifier in eight bits.
// - Secure isolation status holds first-raiser identifier in eight bits.
// - Secure registers answer only Secure accesses.
// - Non-secure copies answer any access.
// - Monitor registers absent when no endpoint in domain is monitored.
// - Endpoint status and control pair always present.
// - Endpoint status reports Non-secure errors with the common layout.
// - Secure isolation status reports isolated accesses by Secure transactions.
module pmi_bank #(
    parameter int NPORT = 8,
    parameter bit MONITOR_EN = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic secure_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic [pmi_pkg::NCAT-1:0] cat_irq_o,
    input wire logic [pmi_pkg::NCAT*NPORT-1:0] event_i,
    input wire logic [pmi_pkg::NCAT*NPORT-1:0] role_i,
    input wire logic [NPORT*pmi_pkg::TAG_W-1:0] tag_i
);
    localparam int NC = pmi_pkg::NCAT;
    if (NPORT < 1 || NPORT > 511) begin : g_bad_nport
        $error("pmi_bank: NPORT out of range");
    end

    typedef struct packed {
        logic [NC*NPORT-1:0] ev_s1;
        logic [NC*NPORT-1:0] ev_s2;
        logic [NC*NPORT-1:0] role_s1;
        logic [NC*NPORT-1:0] role_s2;
        logic [NC-1:0] mask;
        logic [NC-1:0] irq_stat;
        logic [NC-1:0] irq_en;
        logic [31:0] rdata;
        logic irq;
        logic [NC-1:0] cat_irq;
    } pmi_bank_state_t;

    pmi_bank_state_t st, next_st;

    logic [NC*pmi_pkg::COUNT_W-1:0] cnt;
    logic [NC-1:0] role;
    logic [NC*pmi_pkg::TAG_W-1:0] tag;
    logic [NC-1:0] rise;

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_cat
            pmi_category #(.NPORT(NPORT)) u_cat (
                .ref_clk_i(ref_clk_i),
                .srst_i(srst_i),
                .req_i(st.ev_s2[g*NPORT +: NPORT]),
                .role_i(st.role_s2[g*NPORT +: NPORT]),
                .tag_i(tag_i),
                .count_o(cnt[g*pmi_pkg::COUNT_W +: pmi_pkg::COUNT_W]),
                .role_o(role[g]),
                .tag_o(tag[g*pmi_pkg::TAG_W +: pmi_pkg::TAG_W]),
                .rise_o(rise[g])
            );
        end
    endgenerate

    // Index of a category register, or -1 when unmapped or refused
    function automatic int cat_of(input logic [7:0] a, input logic sec, input logic ctl);
        int c;
        c = -1;
        case (a)
            pmi_pkg::OFS_RESET_MASK_S: if (ctl) c = pmi_pkg::CAT_RESET;
            pmi_pkg::OFS_ISO_STATUS_S: if (!ctl) c = pmi_pkg::CAT_ISO;
            pmi_pkg::OFS_ISO_MASK_S: if (ctl) c = pmi_pkg::CAT_ISO;
            pmi_pkg::OFS_EP_STATUS_NS: if (!ctl) c = pmi_pkg::CAT_EP;
            pmi_pkg::OFS_EP_MASK_NS: if (ctl) c = pmi_pkg::CAT_EP;
            pmi_pkg::OFS_FAULT_STATUS_NS: if (!ctl) c = pmi_pkg::CAT_FAULT;
            pmi_pkg::OFS_FAULT_MASK_NS: if (ctl) c = pmi_pkg::CAT_FAULT;
            default: c = -1;
        endcase
        if ((c == pmi_pkg::CAT_RESET || c == pmi_pkg::CAT_ISO) && !sec) c = -1;
        if (c != pmi_pkg::CAT_EP && !MONITOR_EN) c = -1;
        return c;
    endfunction

    always_comb begin
        int c;
        logic [NC-1:0] clr;
        c = -1;
        clr = '0;
        next_st = st;
        next_st.ev_s1 = event_i;
        next_st.ev_s2 = st.ev_s1;
        next_st.role_s1 = role_i;
        next_st.role_s2 = st.role_s1;
        next_st.rdata = '0;
        if (wr_i) begin
            c = cat_of(addr_i, secure_i, 1'b1);
            if (c >= 0) next_st.mask[c] = wdata_i[pmi_pkg::MASK_BIT];
            if (addr_i == pmi_pkg::OFS_IRQ_ENABLE) next_st.irq_en = wdata_i[NC-1:0];
            if (addr_i == pmi_pkg::OFS_IRQ_CLEAR) clr = wdata_i[NC-1:0];
        end
        // Set wins over clear in the same cycle
        next_st.irq_stat = (st.irq_stat & ~clr) | (rise & ~st.mask);
        if (rd_i) begin
            c = cat_of(addr_i, secure_i, 1'b0);
            if (c >= 0) begin
                // Reserved bits read as zero
                next_st.rdata[pmi_pkg::COUNT_LSB +: pmi_pkg::COUNT_W] =
                    cnt[c*pmi_pkg::COUNT_W +: pmi_pkg::COUNT_W];
                next_st.rdata[pmi_pkg::ROLE_BIT] = role[c];
                next_st.rdata[pmi_pkg::TAG_LSB +: pmi_pkg::TAG_W] =
                    tag[c*pmi_pkg::TAG_W +: pmi_pkg::TAG_W];
            end
            c = cat_of(addr_i, secure_i, 1'b1);
            if (c >= 0) next_st.rdata[pmi_pkg::MASK_BIT] = st.mask[c];
            if (addr_i == pmi_pkg::OFS_IRQ_STATUS) next_st.rdata[NC-1:0] = st.irq_stat;
            if (addr_i == pmi_pkg::OFS_IRQ_ENABLE) next_st.rdata[NC-1:0] = st.irq_en;
        end
        next_st.irq = |(next_st.irq_stat & next_st.irq_en);
        for (int i = 0; i < NC; i++) begin
            // Level per category: someone asserting and not masked
            next_st.cat_irq[i] = (cnt[i*pmi_pkg::COUNT_W +: pmi_pkg::COUNT_W] != '0)
                && !next_st.mask[i];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.mask <= {NC{pmi_pkg::MASK_RST}};
            st.irq_en <= pmi_pkg::IRQ_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign irq_o = st.irq;
    assign cat_irq_o = st.cat_irq;
endmodule // pmi_bank

// ### verification/pmi_bank_sva.sv
`timescale 1ns/1ps
module pmi_bank_sva #(
    parameter int NPORT = 8,
    parameter bit MONITOR_EN = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic secure_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire logic [pmi_pkg::NCAT-1:0] cat_irq_o,
    input wire logic [pmi_pkg::NCAT*NPORT-1:0] event_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence wr_s(a, d, s);
        wr_i && addr_i == a && wdata_i == d && secure_i == s;
    endsequence
    sequence rd_s(a, s);
        rd_i && addr_i == a && secure_i == s;
    endsequence
    a_read_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_secure_read_block: assert property (
        rd_i && !secure_i && addr_i <= 8'h08 |=> rdata_o == 32'h0)
        else $error("secure register answered a non-secure read");
    a_secure_write_block: assert property (wr_s(8'h08, 0, 1) ##1 wr_s(8'h08, 1, 0)
        ##1 rd_s(8'h08, 1) |=> rdata_o == 32'h0) else $error("non-secure write reached secure mask");
    // Without monitoring the secure mask is absent and reads back zero
    a_secure_mask_rw: assert property (
        wr_s(8'h00, 1, 1) ##1 rd_s(8'h00, 1) |=> rdata_o == {31'h0, MONITOR_EN})
        else $error("secure mask did not read back");
    a_open_mask_rw: assert property (
        wr_s(8'h10, 1, 0) ##1 rd_s(8'h10, 0) |=> rdata_o == 32'h1)
        else $error("non-secure mask did not read back");
    a_mask_blocks_irq: assert property (
        wr_i && addr_i == 8'h18 && wdata_i[0] && MONITOR_EN |=> !cat_irq_o[3])
        else $error("masked fault category still raised");
    a_quiet_no_count: assert property ((event_i == '0) [*6] |-> cat_irq_o == '0)
        else $error("category raised with no interface asserting");
    // The idle cycle keeps the enables from being rewritten; irq_o itself falls one edge after the write
    a_enable_off_irq: assert property (wr_i && addr_i == 8'h20 && wdata_i[3:0] == 4'h0
        ##1 !(wr_i && addr_i == 8'h20) |=> !irq_o) else $error("interrupt high with enables off");
endmodule // pmi_bank_sva
bind pmi_bank pmi_bank_sva #(.NPORT(NPORT), .MONITOR_EN(MONITOR_EN)) u_sva (.ref_clk_i,
    .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .secure_i, .rdata_o, .irq_o, .cat_irq_o,
    .event_i);

// ### verification/tb_pmi_bank.sv
`timescale 1ns/1ps
module tb_pmi_bank;
    localparam int NP = 8;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic secure_i = 1'b0;
    logic [31:0] rdata_o;
    logic irq_o;
    logic [3:0] cat_irq_o;
    logic [4*NP-1:0] event_i = '0;
    logic [4*NP-1:0] role_i = '0;
    logic [NP*8-1:0] tag_i = '0;
    logic [31:0] v;
    logic [31:0] vb;
    logic [31:0] rdata_bare;
    logic [3:0] cat_bare;
    logic [NP-1:0] ev;
    logic [7:0] ma [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
    logic [7:0] sa [4] = '{8'h1C, 8'h04, 8'h0C, 8'h14};
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    pmi_bank #(.NPORT(NP)) u_dut (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .secure_i, .rdata_o, .irq_o, .cat_irq_o, .event_i, .role_i, .tag_i);
    // Same stimulus with monitoring absent: of the category registers only the endpoint pair may answer
    pmi_bank #(.NPORT(NP), .MONITOR_EN(1'b0)) u_dut_bare (.ref_clk_i, .srst_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .secure_i, .rdata_o(rdata_bare), .irq_o(),
        .cat_irq_o(cat_bare), .event_i, .role_i, .tag_i);
    always #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("TB: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Strobes are left up so calls run back to back; v and vb hold read data
    // as they stood in the cycle that this edge closes
    task automatic bus(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d,
        input logic s);
        @(posedge ref_clk_i);
        v = rdata_o;
        vb = rdata_bare;
        addr_i <= a;
        wdata_i <= d;
        secure_i <= s;
        wr_i <= op[0];
        rd_i <= op[1];
    endtask
    // Read data stand in the cycle after the strobe and are taken at its closing edge
    task automatic rchk(input logic [7:0] a, input logic s, input logic [31:0] e);
        bus(2'd2, a, 32'h0, s);
        bus(2'd0, 8'h0, 32'h0, 1'b0);
        bus(2'd0, 8'h0, 32'h0, 1'b0);
        chk(v, e);
    endtask
    task automatic bchk(input logic [7:0] a, input logic [31:0] e);
        bus(2'd2, a, 32'h0, 1'b1);
        bus(2'd0, 8'h0, 32'h0, 1'b0);
        bus(2'd0, 8'h0, 32'h0, 1'b0);
        chk(vb, e);
    endtask
    // Leaves enough quiet cycles for the two-flop event sync and registered flags
    task automatic pause();
        bus(2'd0, 8'h0, 32'h0, 1'b0);
        repeat (8) @(posedge ref_clk_i);
    endtask
    function automatic logic [31:0] stat(input logic [NP-1:0] f, a, input int c);
        int k = 0;
        while (!f[k]) k++;
        return {7'h0, 9'($countones(a)), 7'h0, role_i[c*NP+k], tag_i[k*8+:8]};
    endfunction
    initial begin
        void'($urandom(32'h6749));
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        foreach (ma[i]) begin
            rchk(ma[i], 1'b1, 32'h0);
            bus(2'd1, ma[i], 32'h0, 1'b1);
            bus(2'd1, ma[i], 32'h1, 1'b0);
            rchk(ma[i], 1'b1, {31'h0, i > 1});
            bus(2'd1, ma[i], 32'h1, i < 2);
            rchk(ma[i], i < 2, 32'h1);
            rchk(ma[i], 1'b0, {31'h0, i > 1});
            bus(2'd1, ma[i], 32'h0, 1'b1);
        end
        rchk(8'h30, 1'b1, 32'h0);
        $display("TB: test mask access done");
        tag_i <= {$urandom, $urandom};
        bus(2'd1, 8'h20, 32'hF, 1'b0);
        for (int c = 0; c < 4; c++) begin
            ev = 8'($urandom) | 8'h10;
            role_i <= $urandom;
            event_i[c*NP+:NP] <= ev;
            pause();
            chk(cat_irq_o[c], 1'b1);
            if (c > 0) rchk(sa[c], 1'b1, stat(ev, ev, c));
            event_i[c*NP+:NP] <= ev | 8'h01;
            pause();
            if (c > 0) rchk(sa[c], 1'b1, stat(ev, ev | 8'h01, c));
            rchk(8'h1C, 1'b0, 32'h1 << c);
            chk(irq_o, 1'b1);
            event_i <= '0;
            pause();
            bus(2'd1, 8'h24, 32'hF, 1'b0);
            rchk(8'h1C, 1'b0, 32'h0);
            chk(irq_o, 1'b0);
            bus(2'd1, ma[c], 32'h1, c < 2);
            // A later first raiser, so a fresh capture after the count was zero shows
            ev = (ev & (ev - 8'h01)) | 8'h80;
            event_i[c*NP+:NP] <= ev;
            pause();
            chk(cat_irq_o[c], 1'b0);
            chk(irq_o, 1'b0);
            if (c > 0) rchk(sa[c], 1'b1, stat(ev, ev, c));
            event_i <= '0;
            pause();
            bus(2'd1, ma[c], 32'h0, 1'b1);
            $display("TB: test category %0d done", c);
        end
        foreach (ma[i]) begin
            bus(2'd1, ma[i], 32'h1, 1'b1);
            bchk(ma[i], {31'h0, i == 2});
            bus(2'd1, ma[i], 32'h0, 1'b1);
        end
        event_i[2*NP+:NP] <= ev;
        pause();
        bchk(8'h0C, stat(ev, ev, 2));
        bchk(8'h14, 32'h0);
        chk(cat_bare[2], 1'b1);
        event_i <= '0;
        pause();
        $display("TB: test bare configuration done");
        bus(2'd1, 8'h20, 32'h0, 1'b0);
        rchk(8'h20, 1'b0, 32'h0);
        close_out();
    end
endmodule // tb_pmi_bank
